// *** fspc_pkg.sv ***
// constants shared by the flash self-program controller and its core end
// assumes one 50 MHz clock and a synchronous active-low reset everywhere
//
// Functional notes
// RULE1 - program store erased by whole 32-word rows
// RULE2 - row of 32 words, 32 write latches
// RULE3 - latches filled only through data byte pair
// RULE4 - blank words programmable without erase
// RULE5 - core loads address, clears config select, fetches
// RULE6 - second slot after fetch is discarded access
// RULE7 - fetched word in data pair next cycle
// RULE8 - data pair holds until fetch or write
// RULE9 - core places two no-ops after fetch trigger
// RULE10 - modify operations need uninterrupted key sequence
// RULE11 - key order: 55h, AAh, trigger, two no-ops
// RULE12 - program trigger forces two no-op slots
// RULE13 - erase or program stalls execution about 2 ms
// RULE14 - latch load: forced no-ops, no stall
// RULE15 - core keeps interrupts off during key sequence
// RULE16 - triggers set by software, cleared by hardware
// RULE17 - modify needs enable; abort flag on reset
// RULE18 - key register reads back as zero
// RULE19 - latch-only select picks latch load or program
// RULE20 - intervening write discards partial key sequence
`default_nettype none

package fspc_pkg;
  // -----------------------------------------------------------
  // memory shape
  // -----------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int ADDR_W = 15;
  localparam int ROW_WORDS = 32;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;

  // -----------------------------------------------------------
  // link register selects and control bit positions
  // -----------------------------------------------------------
  localparam logic [2:0] SEL_ADDR_LO = 3'h0;
  localparam logic [2:0] SEL_ADDR_HI = 3'h1;
  localparam logic [2:0] SEL_DATA_LO = 3'h2;
  localparam logic [2:0] SEL_DATA_HI = 3'h3;
  localparam logic [2:0] SEL_CTRL = 3'h4;
  localparam logic [2:0] SEL_KEY = 3'h5;
  localparam int B_FETCH = 0;
  localparam int B_PROG = 1;
  localparam int B_EN = 2;
  localparam int B_ABORT = 3;
  localparam int B_ERASE = 4;
  localparam int B_LATCH = 5;
  localparam int B_CONFIG_SPACE_SELECT = 6;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // -----------------------------------------------------------
  // timing
  // -----------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int ERASE_TIME_US = 2000;
  localparam int ERASE_CYC_DEF = ERASE_TIME_US * CLK_MHZ;

  // -----------------------------------------------------------
  // core end apb map and commands
  // -----------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  typedef enum logic [1:0] {OP_READ, OP_ERASE, OP_LOAD, OP_PROG} fspc_op_t;
endpackage : fspc_pkg

`default_nettype wire

// *** fspc_link_if.sv ***
// instruction-slot link between the core end and the flash controller
// assumes both ends clocked by sys_clk_in; one request per slot
`timescale 1ns/1ns
`default_nettype none

interface fspc_link_if (
  input wire logic sys_clk_in
);
  logic cyc;
  logic we;
  logic [2:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic discard;
  logic stall;

  modport dev (input cyc, we, sel, wdata, output rdata, discard, stall);
  modport core (output cyc, we, sel, wdata, input rdata, discard, stall);
endinterface : fspc_link_if

`default_nettype wire

// *** fspc_dev.sv ***
// flash self-program controller: registers, key lock, latches, array
// assumes the core end presents at most one register access per cycle
`timescale 1ns/1ns
`default_nettype none

module fspc_dev #(
  parameter int ERASE_CYC = fspc_pkg::ERASE_CYC_DEF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // link to the core
  fspc_link_if.dev lnk,
  // user-side status
  output logic op_active_out,
  output logic abort_flag_out
);
  import fspc_pkg::*;

  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  typedef enum logic [1:0] {KS_IDLE, KS_FIRST, KS_ARMED} fspc_key_t;
  localparam int CNT_W = $clog2(ERASE_CYC + 1);

  fspc_key_t key_q;
  logic [7:0] adr_lo_q;
  logic [6:0] adr_hi_q;
  logic [7:0] dat_lo_q;
  logic [5:0] dat_hi_q;
  logic fetch_q, prog_q, en_q, abort_q, erase_q, latch_q, config_space_select_q;
  logic [1:0] slot_q;
  logic kind_fetch_q;
  logic discard_q;
  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] rdata_q;
  // contents start blank at power-up, reset leaves them alone
  logic [WORD_W-1:0] flash_mem [0:(2**ADDR_W)-1] = '{default: BLANK_WORD};
  logic [WORD_W-1:0] latch_mem [0:ROW_WORDS-1] = '{default: BLANK_WORD};

  logic acc, wr, wr_ctrl, wr_key, launch, fetch_go, slot_end, walk;
  logic [4:0] idx;
  logic [ADDR_W-1:0] row_addr;

  assign lnk.rdata = rdata_q;
  assign lnk.discard = discard_q;
  assign lnk.stall = busy_q;
  assign op_active_out = prog_q;
  assign abort_flag_out = abort_q;

  // -----------------------------------------------------------
  // access decode
  // -----------------------------------------------------------
  // slots marked discard or stalled never reach the registers
  assign acc = lnk.cyc && !discard_q && !busy_q; // RULE12
  assign wr = acc && lnk.we;
  assign wr_ctrl = wr && (lnk.sel == SEL_CTRL);
  assign wr_key = wr && (lnk.sel == SEL_KEY);
  // trigger only after both keys, with enable, no op running
  assign launch = wr_ctrl && lnk.wdata[B_PROG] && (key_q == KS_ARMED) && lnk.wdata[B_EN] && !lnk.wdata[B_CONFIG_SPACE_SELECT]
                  && !prog_q && !fetch_q; // RULE10 RULE17
  assign fetch_go = wr_ctrl && lnk.wdata[B_FETCH] && !fetch_q && !prog_q;
  assign slot_end = (slot_q == 2'd2);
  assign walk = busy_q && (cnt_q < CNT_W'(ROW_WORDS));
  assign idx = cnt_q[4:0];
  assign row_addr = {adr_hi_q, adr_lo_q[7:5], idx}; // RULE1 RULE2

  // -----------------------------------------------------------
  // key sequence
  // -----------------------------------------------------------
  // any other write in between drops the partial sequence
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      key_q <= KS_IDLE;
    end else if (wr) begin
      if (wr_key && lnk.wdata == KEY_FIRST) begin
        key_q <= KS_FIRST;
      end else if (wr_key && lnk.wdata == KEY_SECOND && key_q == KS_FIRST) begin
        key_q <= KS_ARMED;
      end else begin
        key_q <= KS_IDLE; // RULE20
      end
    end
  end

  // -----------------------------------------------------------
  // control register
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      en_q <= CTRL_RESET[B_EN]; // RULE17
      erase_q <= CTRL_RESET[B_ERASE];
      latch_q <= CTRL_RESET[B_LATCH];
      config_space_select_q <= CTRL_RESET[B_CONFIG_SPACE_SELECT];
    end else if (wr_ctrl) begin
      en_q <= lnk.wdata[B_EN];
      erase_q <= lnk.wdata[B_ERASE];
      latch_q <= lnk.wdata[B_LATCH];
      config_space_select_q <= lnk.wdata[B_CONFIG_SPACE_SELECT];
    end
  end

  // software writes of zero to the triggers have no effect
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fetch_q <= CTRL_RESET[B_FETCH];
    end else if (fetch_go) begin
      fetch_q <= 1'b1;
    end else if (slot_end && kind_fetch_q) begin
      fetch_q <= 1'b0; // RULE16
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      prog_q <= CTRL_RESET[B_PROG];
    end else if (launch) begin
      prog_q <= 1'b1;
    end else if ((slot_end && !kind_fetch_q && latch_q) || (busy_q && cnt_q == CNT_W'(ERASE_CYC - 1))) begin
      prog_q <= 1'b0; // RULE16
    end
  end

  // reset during a stall leaves the abort flag behind
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      // sticky for the whole reset: its first edge already clears busy and trigger
      if (busy_q || prog_q || abort_q) begin
        abort_q <= 1'b1; // RULE17
      end else begin
        abort_q <= 1'b0;
      end
    end else if (wr_ctrl && !lnk.wdata[B_ABORT]) begin
      abort_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // forced slots after a trigger
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      slot_q <= 2'd0;
      kind_fetch_q <= 1'b0;
    end else if (launch || fetch_go) begin
      slot_q <= 2'd1;
      kind_fetch_q <= fetch_go;
    end else if (slot_q != 2'd0) begin
      slot_q <= slot_end ? 2'd0 : 2'd2;
    end
  end

  // fetch: first slot runs, second is the array access
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      discard_q <= 1'b0;
    end else if (launch) begin
      discard_q <= 1'b1; // RULE12 RULE14
    end else if (fetch_go) begin
      discard_q <= 1'b0;
    end else if (slot_q == 2'd1) begin
      discard_q <= 1'b1; // RULE6
    end else if (slot_end) begin
      discard_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------
  // erase / program stall
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (slot_end && !kind_fetch_q && !latch_q) begin
      busy_q <= 1'b1; // RULE13
      cnt_q <= '0;
    end else if (busy_q) begin
      if (cnt_q == CNT_W'(ERASE_CYC - 1)) begin
        busy_q <= 1'b0; // RULE13
      end
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // -----------------------------------------------------------
  // address and data pairs
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      adr_lo_q <= 8'h00;
      adr_hi_q <= 7'h00;
    end else if (wr && lnk.sel == SEL_ADDR_LO) begin
      adr_lo_q <= lnk.wdata;
    end else if (wr && lnk.sel == SEL_ADDR_HI) begin
      adr_hi_q <= lnk.wdata[6:0];
    end
  end

  // config space is not backed here: a fetch there returns blank
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dat_lo_q <= 8'h00;
      dat_hi_q <= 6'h00;
    end else if (slot_end && kind_fetch_q) begin
      {dat_hi_q, dat_lo_q} <= config_space_select_q ? BLANK_WORD : flash_mem[{adr_hi_q, adr_lo_q}]; // RULE7 RULE8
    end else if (wr && lnk.sel == SEL_DATA_LO) begin
      dat_lo_q <= lnk.wdata; // RULE8
    end else if (wr && lnk.sel == SEL_DATA_HI) begin
      dat_hi_q <= lnk.wdata[5:0];
    end
  end

  // -----------------------------------------------------------
  // read back
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (acc && !lnk.we) begin
      unique case (lnk.sel)
        SEL_ADDR_LO: rdata_q <= adr_lo_q;
        SEL_ADDR_HI: rdata_q <= {1'b0, adr_hi_q};
        SEL_DATA_LO: rdata_q <= dat_lo_q;
        SEL_DATA_HI: rdata_q <= {2'b00, dat_hi_q};
        SEL_CTRL: rdata_q <= {1'b0, config_space_select_q, latch_q, erase_q, abort_q, en_q, prog_q, fetch_q};
        SEL_KEY: rdata_q <= 8'h00; // RULE18
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // -----------------------------------------------------------
  // write latches
  // -----------------------------------------------------------
  // no direct port to the latches; only the data pair feeds them
  always_ff @(posedge sys_clk_in) begin
    if (slot_end && !kind_fetch_q && !erase_q) begin
      latch_mem[adr_lo_q[4:0]] <= {dat_hi_q, dat_lo_q}; // RULE3 RULE19
    end else if (walk) begin
      latch_mem[idx] <= BLANK_WORD;
    end
  end

  // -----------------------------------------------------------
  // program array
  // -----------------------------------------------------------
  // one word per cycle during the stall keeps it a single-port memory
  always_ff @(posedge sys_clk_in) begin
    if (walk) begin
      if (erase_q) begin
        flash_mem[row_addr] <= BLANK_WORD; // RULE1 RULE2
      end else begin
        // programming only clears bits, so blank words need no erase
        flash_mem[row_addr] <= flash_mem[row_addr] & latch_mem[idx]; // RULE4 RULE19
      end
    end
  end
endmodule : fspc_dev

`default_nettype wire

// *** fspc_core.sv ***
// core end: replays self-programming sequences ordered over apb
// assumes the apb master and the link share sys_clk_in
`timescale 1ns/1ns
`default_nettype none

module fspc_core (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // link to the controller
  fspc_link_if.core lnk,
  // user-side status
  output logic busy_out
);
  import fspc_pkg::*;

  // -----------------------------------------------------------
  // state
  // -----------------------------------------------------------
  fspc_op_t op_q;
  logic [14:0] addr_q;
  logic [13:0] data_q;
  logic busy_q;
  logic [3:0] step_q;
  logic cyc_q, we_q, rd_v_q;
  logic [2:0] sel_q, rd_sel_q;
  logic [7:0] wdata_q;
  logic apb_wr, setup;
  logic a_issue, a_we, a_last, adv;
  logic [2:0] a_sel;
  logic [7:0] a_data, ctrl_v;

  assign lnk.cyc = cyc_q;
  assign lnk.we = we_q;
  assign lnk.sel = sel_q;
  assign lnk.wdata = wdata_q;
  assign busy_out = busy_q;
  assign setup = psel_in && !penable_in;
  assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;

  // -----------------------------------------------------------
  // apb slave
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= setup;
      pslverr_out <= setup && !(paddr_in inside {OFS_CMD, OFS_ADDR, OFS_DATA, OFS_STAT});
      if (setup) begin
        unique case (paddr_in)
          OFS_CMD: prdata_out <= {30'd0, op_q};
          OFS_ADDR: prdata_out <= {17'd0, addr_q};
          OFS_DATA: prdata_out <= {18'd0, data_q};
          OFS_STAT: prdata_out <= {30'd0, lnk.stall, busy_q};
          default: prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // -----------------------------------------------------------
  // sequence steps
  // -----------------------------------------------------------
  // each op's steps are issued in order with nothing else interleaved
  assign ctrl_v = (8'h01 << B_EN) | (op_q == OP_ERASE ? (8'h01 << B_ERASE) : 8'h00)
                  | (op_q == OP_LOAD ? (8'h01 << B_LATCH) : 8'h00);
  always_comb begin
    a_issue = 1'b1;
    a_we = 1'b1;
    a_sel = SEL_CTRL;
    a_data = 8'h00;
    a_last = 1'b0;
    unique case (step_q)
      4'd0: begin a_sel = SEL_ADDR_LO; a_data = addr_q[7:0]; end // RULE5
      4'd1: begin a_sel = SEL_ADDR_HI; a_data = {1'b0, addr_q[14:8]}; end
      4'd2: begin
        a_sel = (op_q == OP_READ) ? SEL_CTRL : SEL_DATA_LO;
        a_data = (op_q == OP_READ) ? 8'h00 : data_q[7:0]; // RULE5
      end
      4'd3: begin
        a_sel = (op_q == OP_READ) ? SEL_CTRL : SEL_DATA_HI;
        a_data = (op_q == OP_READ) ? (8'h01 << B_FETCH) : {2'b00, data_q[13:8]};
      end
      4'd4: begin a_issue = (op_q != OP_READ); a_data = ctrl_v; end // RULE9
      4'd5: begin a_issue = (op_q != OP_READ); a_sel = SEL_KEY; a_data = KEY_FIRST; end // RULE9 RULE11
      4'd6: begin
        a_we = (op_q != OP_READ);
        a_sel = (op_q == OP_READ) ? SEL_DATA_LO : SEL_KEY;
        a_data = KEY_SECOND; // RULE11
      end
      4'd7: begin
        a_we = (op_q != OP_READ);
        a_sel = (op_q == OP_READ) ? SEL_DATA_HI : SEL_CTRL;
        a_data = ctrl_v | (8'h01 << B_PROG); // RULE10 RULE11
      end
      4'd8: a_issue = 1'b0; // RULE11
      4'd9: begin a_issue = 1'b0; a_last = (op_q == OP_READ); end // RULE11
      default: begin a_data = 8'h00; a_last = 1'b1; end // RULE15
    endcase
  end

  // real requests wait out forced slots and stalls, idle slots do not
  assign adv = busy_q && (!a_issue || (!lnk.stall && !lnk.discard)); // RULE13

  // -----------------------------------------------------------
  // command, step and link drive
  // -----------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      step_q <= 4'd0;
      op_q <= OP_READ;
      addr_q <= 15'h0000;
    end else if (!busy_q) begin
      if (apb_wr && paddr_in == OFS_CMD) begin
        op_q <= fspc_op_t'(pwdata_in[1:0]);
        busy_q <= 1'b1;
        step_q <= 4'd0;
      end else if (apb_wr && paddr_in == OFS_ADDR) begin
        addr_q <= pwdata_in[14:0];
      end
    end else if (adv) begin
      busy_q <= !a_last;
      step_q <= step_q + 4'd1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cyc_q <= 1'b0;
      we_q <= 1'b0;
      sel_q <= SEL_ADDR_LO;
      wdata_q <= 8'h00;
    end else begin
      cyc_q <= adv && a_issue;
      we_q <= a_we;
      sel_q <= a_sel;
      wdata_q <= a_data;
    end
  end

  // read answers arrive one cycle after the request
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rd_v_q <= 1'b0;
      rd_sel_q <= SEL_DATA_LO;
      data_q <= 14'h0000;
    end else begin
      rd_v_q <= cyc_q && !we_q;
      rd_sel_q <= sel_q;
      if (rd_v_q && rd_sel_q == SEL_DATA_LO) begin
        data_q[7:0] <= lnk.rdata;
      end else if (rd_v_q && rd_sel_q == SEL_DATA_HI) begin
        data_q[13:8] <= lnk.rdata[5:0];
      end else if (!busy_q && apb_wr && paddr_in == OFS_DATA) begin
        data_q <= pwdata_in[13:0];
      end
    end
  end
endmodule : fspc_core

`default_nettype wire

// *** fspc_link_asserts.sv ***
// link checker: slot, discard and stall timing of the controller
// assumes it sits beside the link interface inside the testbench
`timescale 1ns/1ns
`default_nettype none

module fspc_link_asserts #(
  parameter int ERASE_CYC = fspc_pkg::ERASE_CYC_DEF
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // link signals
  input wire logic cyc,
  input wire logic we,
  input wire logic [2:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic discard,
  input wire logic stall
);
  import fspc_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ------------------------------
  // helpers
  // ------------------------------
  logic take;
  logic ctl_wr;
  logic prog_go;
  int stall_cnt_q;
  assign take = cyc && !discard && !stall;
  assign ctl_wr = take && we && sel == SEL_CTRL;
  // the core always arms the key first, so trigger plus enable is a real start
  assign prog_go = ctl_wr && wdata[B_PROG] && wdata[B_EN] && !wdata[B_CONFIG_SPACE_SELECT];
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      stall_cnt_q <= 0;
    end else begin
      stall_cnt_q <= stall ? stall_cnt_q + 1 : 0;
    end
  end

  // ------------------------------
  // properties
  // ------------------------------
  AST_FETCH_SLOT: assert property (ctl_wr && wdata[B_FETCH] |=> !discard ##1 discard ##1 !discard)
    else $error("fetch access slot misplaced");
  AST_PROG_NOPS: assert property (prog_go |=> discard [*2])
    else $error("program trigger without two forced slots");
  AST_NO_THIRD_NOP: assert property (discard ##1 discard |=> !discard)
    else $error("more than two forced slots");
  AST_LATCH_NO_STALL: assert property (prog_go && wdata[B_LATCH] && !wdata[B_ERASE] |-> ##3 !stall)
    else $error("latch load stalled");
  AST_ROW_STALL: assert property (prog_go && !(wdata[B_LATCH] && !wdata[B_ERASE]) |-> ##3 stall)
    else $error("row operation did not stall");
  AST_STALL_LEN: assert property ($fell(stall) |-> stall_cnt_q == ERASE_CYC)
    else $error("stall length wrong");
  AST_STALL_ENTRY: assert property ($rose(stall) |-> $past(discard) && !discard)
    else $error("stall not right after forced slots");
  AST_QUIET_IN_STALL: assert property (stall |-> !discard)
    else $error("discard during stall");
  AST_RDATA_HOLD: assert property (!(take && !we) |=> $stable(rdata))
    else $error("read data changed without a read");

  cover property (ctl_wr && wdata[B_FETCH]);
  cover property (prog_go);
  cover property ($fell(stall));
endmodule : fspc_link_asserts

`default_nettype wire

// *** tb_top.sv ***
// testbench: core and controller joined by the link, driven over apb
// assumes the design files and the link checker compile before it
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import fspc_pkg::*;
  localparam int ERASE_CYC = 40;
  typedef struct packed {
    fspc_op_t op;
    logic [14:0] a;
    logic [13:0] d;
    logic [14:0] ra;
    logic [13:0] exp;
  } fspc_row_t;
  logic sys_clk;
  logic rst_n;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, busy, er, act, abrt;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt = 0;
  int checks = 0;
  fspc_row_t rows [9];

  fspc_link_if lnk (.sys_clk_in(sys_clk));
  fspc_link_if l2 (.sys_clk_in(sys_clk));
  fspc_core i_fspc_core (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .lnk(lnk.core), .busy_out(busy));
  fspc_dev #(.ERASE_CYC(ERASE_CYC)) i_fspc_dev (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .lnk(lnk.dev), .op_active_out(act), .abort_flag_out(abrt));
  // second controller faces the bench so that broken key orders can be sent
  fspc_dev #(.ERASE_CYC(ERASE_CYC)) i_fspc_dev_2 (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .lnk(l2.dev), .op_active_out(), .abort_flag_out());
  fspc_link_asserts #(.ERASE_CYC(ERASE_CYC)) i_fspc_link_asserts (.sys_clk_in(sys_clk),
    .rst_n_in(rst_n), .cyc(lnk.cyc), .we(lnk.we), .sel(lnk.sel), .wdata(lnk.wdata),
    .rdata(lnk.rdata), .discard(lnk.discard), .stall(lnk.stall));

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : cmp

  task automatic stop_test;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic poll(input int b, input logic v);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    while (rd[b] !== v) begin
      apb(1'b0, OFS_STAT, 32'h0000_0000);
    end
  endtask : poll

  task automatic run_cmd(input fspc_op_t op, input logic [14:0] a, input logic [13:0] d);
    apb(1'b1, OFS_ADDR, {17'h0_0000, a});
    apb(1'b1, OFS_DATA, {18'h0_0000, d});
    apb(1'b1, OFS_CMD, {30'h0000_0000, op});
    cmp({31'h0000_0000, busy}, 32'h0000_0001);
    poll(0, 1'b0);
    cmp({31'h0000_0000, act}, 32'h0000_0000);
  endtask : run_cmd

  // one slot on the second link, then an idle slot
  task automatic lk(input logic w, input logic [2:0] s, input logic [7:0] d);
    l2.cyc <= 1'b1;
    l2.we <= w;
    l2.sel <= s;
    l2.wdata <= d;
    @(posedge sys_clk);
    l2.cyc <= 1'b0;
    @(posedge sys_clk);
  endtask : lk

  task automatic lrd(input logic [2:0] s, input logic [7:0] exp);
    lk(1'b0, s, 8'h00);
    #1;
    cmp({24'h00_0000, l2.rdata}, {24'h00_0000, exp});
    @(posedge sys_clk);
  endtask : lrd

  // ------------------------------
  // stimulus
  // ------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {l2.cyc, l2.we, l2.sel, l2.wdata} = 13'h0000;
    rows = '{
      '{OP_READ, 15'h0040, 14'h0000, 15'h0040, 14'h3fff},
      '{OP_LOAD, 15'h0041, 14'h1234, 15'h0041, 14'h3fff},
      '{OP_PROG, 15'h0042, 14'h2aaa, 15'h0042, 14'h2aaa},
      '{OP_READ, 15'h0000, 14'h0000, 15'h0041, 14'h1234},
      '{OP_PROG, 15'h0060, 14'h0155, 15'h0060, 14'h0155},
      '{OP_PROG, 15'h0042, 14'h3c3c, 15'h0042, 14'h2828},
      '{OP_ERASE, 15'h005f, 14'h0000, 15'h0042, 14'h3fff},
      '{OP_READ, 15'h0000, 14'h0000, 15'h0060, 14'h0155},
      '{OP_READ, 15'h0000, 14'h0000, 15'h0041, 14'h3fff}};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp({30'h0000_0000, busy, abrt}, 32'h0000_0000);
    @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i].op != OP_READ) begin
        run_cmd(rows[i].op, rows[i].a, rows[i].d);
      end
      run_cmd(OP_READ, rows[i].ra, 14'h0000);
      apb(1'b0, OFS_DATA, 32'h0000_0000);
      cmp({18'h0_0000, rd[13:0]}, {18'h0_0000, rows[i].exp});
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    cmp({31'h0000_0000, er}, 32'h0000_0001);
    cmp(rd, 32'h0000_0000);
    // reset in mid-stall must leave the abort flag behind
    apb(1'b1, OFS_ADDR, 32'h0000_0080);
    apb(1'b1, OFS_CMD, {30'h0000_0000, OP_PROG});
    poll(1, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    cmp({31'h0000_0000, abrt}, 32'h0000_0001);
    cmp({31'h0000_0000, act}, 32'h0000_0000);
    @(posedge sys_clk);
    run_cmd(OP_READ, 15'h0080, 14'h0000);
    cmp({31'h0000_0000, abrt}, 32'h0000_0000);
    // key broken by a write in between, then a clean key; 8'h26 is trigger, enable, latch-only
    lk(1'b1, SEL_KEY, KEY_FIRST);
    lk(1'b1, SEL_ADDR_LO, 8'h07);
    lk(1'b1, SEL_KEY, KEY_SECOND);
    lk(1'b1, SEL_CTRL, 8'h26);
    #1;
    cmp({31'h0000_0000, l2.discard}, 32'h0000_0000);
    @(posedge sys_clk);
    lk(1'b1, SEL_KEY, KEY_FIRST);
    lk(1'b1, SEL_KEY, KEY_SECOND);
    lk(1'b1, SEL_CTRL, 8'h26);
    #1;
    cmp({31'h0000_0000, l2.discard}, 32'h0000_0001);
    @(posedge sys_clk);
    #1;
    cmp({30'h0000_0000, l2.discard, l2.stall}, 32'h0000_0000);
    @(posedge sys_clk);
    lk(1'b1, SEL_DATA_LO, 8'h3c);
    lrd(SEL_DATA_LO, 8'h3c);
    lk(1'b1, SEL_CTRL, 8'h05);
    @(posedge sys_clk);
    lrd(SEL_DATA_LO, 8'hff);
    lrd(SEL_DATA_HI, 8'h3f);
    lk(1'b1, SEL_ADDR_LO, 8'h00);
    lrd(SEL_DATA_LO, 8'hff);
    lrd(SEL_KEY, 8'h00);
    stop_test();
  end
endmodule : tb_top

`default_nettype wire
